// ==== hdl/smf_filter.sv ====
`timescale 1ns/1ps
`default_nettype none

package smf_pkg;
    // ------------------------------------------------------------
    // Register map (byte offsets on the plain register port)
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] ADDR_DETECT_ENABLE = 3'h0;
    localparam logic [2:0] ADDR_DETECT_STATUS = 3'h1;
    localparam logic [2:0] ADDR_MON1_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_MON2_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_CLOCK_MODE_ONE = 3'h4;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DET1_EN_BIT = 6;
    localparam int DET2_EN_BIT = 7;
    localparam int LEVEL2_STAT_BIT = 3;
    localparam int MON_ENABLE_BIT = 0;
    localparam int MON_BYPASS_BIT = 1;
    localparam int MON_BIT2 = 2;
    localparam int MON2_WDT_FLAG_BIT = 3;
    localparam int MON_DIV_LSB = 4;
    localparam int MON_MODE_BIT = 6;
    localparam int MON_COND_BIT = 7;
    localparam int OSC_STOP_BIT = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DETECT_ENABLE_RST = 8'h00;
    localparam logic [7:0] MON1_CONTROL_RST = 8'h00;
    localparam logic [7:0] MON2_CONTROL_RST = 8'h00;
    localparam logic [7:0] CLOCK_MODE_ONE_RST = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MON2_RST_PULSE_NS = 100;
    localparam int MON2_RST_CYCLES =
        (MON2_RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic bypass;
        logic [1:0] div_sel;
    } smf_filt_cfg_t;
endpackage : smf_pkg

module smf_filter (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic slow_edge,
    input wire smf_pkg::smf_filt_cfg_t cfg,
    input wire logic cmp_level,
    output logic level_out
);
    logic [2:0] cnt_reg;
    logic [2:0] div_max;
    logic tick;
    logic last_reg;
    logic level_reg;

    assign div_max = 3'((4'h1 << cfg.div_sel) - 4'h1);
    assign tick = slow_edge && (cnt_reg == div_max);

    // ------------------------------------------------------------
    // Sampling clock divider
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            cnt_reg <= 3'h0;
        end else if (tick) begin
            cnt_reg <= 3'h0;
        end else if (slow_edge) begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Two-sample agreement
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            last_reg <= 1'b0;
            level_reg <= 1'b0;
        end else if (tick) begin
            last_reg <= cmp_level;
            if (cmp_level == last_reg) begin
                level_reg <= cmp_level;
            end
        end
    end

    // Bypass needs no sampling clock, works with oscillator stopped
    assign level_out = cfg.bypass ? cmp_level : level_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_two_samples_agree: assert property (
        $changed(level_reg) |-> $past(tick) && ($past(cmp_level) == $past(last_reg)))
        else $error("filter level changed without two agreeing samples");
    a_div_no_early: assert property (
        slow_edge |=> cnt_reg == ($past(tick) ? 3'h0 : 3'($past(cnt_reg) + 3'h1)))
        else $error("sampling tick before divider terminal count");
endmodule : smf_filter

`default_nettype wire

// ==== hdl/smf_monitor_ctrl.sv ====
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Software enables circuit 2, waits settling; device shows level-2 compare status.
// - Filter-disable bit 0 routes comparator through filter; 1 bypasses it.
// - Sampling clock is slow oscillator divided by 1, 2, 4 or 8.
// - Sample once per sampling clock; act only when two samples agree.
// - Monitor-2 mode bit: zero gives interrupt, one gives reset.
// - Monitor-2 condition zero fires rising to threshold, one falling.
// - Detection flags clear only by written zero; written one keeps them.
// - Monitor-2 flags survive software, watchdog and monitor-2 resets.

module smf_monitor_ctrl (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    input wire logic [smf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [smf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [smf_pkg::DATA_W-1:0] reg_rdata,
    input wire logic slow_osc_clock,
    input wire logic cmp1_below,
    input wire logic cmp2_below,
    input wire logic wdt_event,
    output logic int_reset_n,
    output logic mon2_irq,
    output logic mon2_reset_req,
    output logic slow_osc_stop
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] detect_enable_reg;
    logic [7:0] detect_status_reg;
    logic [7:0] monitor1_control_reg;
    logic [7:0] monitor2_control_reg;
    logic [7:0] clock_mode_reg_one;
    logic [7:0] rdata_next;
    logic [7:0] rdata_reg;
    logic osc_prev_reg;
    logic slow_edge;
    logic below1;
    logic below2;
    logic below2_prev_reg;
    logic det1_circuit_enable;
    logic det2_circuit_enable;
    logic mon1_armed;
    logic mon2_armed;
    logic mon2_event;
    logic mon2_cross_up;
    logic mon2_cross_down;
    logic wr_mon2;
    logic int_reset_n_reg;
    logic mon2_irq_reg;
    logic mon2_reset_req_reg;
    logic [7:0] rst_cnt_reg;
    logic chg_flag_reg;
    logic wdt_flag_reg;
    logic soft_or_sys;
    smf_pkg::smf_filt_cfg_t cfg1;
    smf_pkg::smf_filt_cfg_t cfg2;

    assign soft_or_sys = sys_rst || soft_rst;
    assign det1_circuit_enable = detect_enable_reg[smf_pkg::DET1_EN_BIT];
    assign det2_circuit_enable = detect_enable_reg[smf_pkg::DET2_EN_BIT];
    assign wr_mon2 = reg_wr && (reg_addr == smf_pkg::ADDR_MON2_CONTROL);

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    // Whole-byte writes let divider, bypass and mode change together
    always_ff @(posedge core_clk) begin
        if (soft_or_sys) begin
            detect_enable_reg <= smf_pkg::DETECT_ENABLE_RST;
            monitor1_control_reg <= smf_pkg::MON1_CONTROL_RST;
            monitor2_control_reg <= smf_pkg::MON2_CONTROL_RST;
            clock_mode_reg_one <= smf_pkg::CLOCK_MODE_ONE_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                smf_pkg::ADDR_DETECT_ENABLE: begin
                    detect_enable_reg <= reg_wdata & 8'hc0;
                end
                smf_pkg::ADDR_MON1_CONTROL: begin
                    monitor1_control_reg <= reg_wdata & 8'hf7;
                end
                smf_pkg::ADDR_MON2_CONTROL: begin
                    monitor2_control_reg <= reg_wdata & 8'hf3;
                end
                smf_pkg::ADDR_CLOCK_MODE_ONE: begin
                    clock_mode_reg_one <= reg_wdata & 8'h10;
                end
                default: begin
                end
            endcase
        end
    end

    assign cfg1.bypass = monitor1_control_reg[smf_pkg::MON_BYPASS_BIT];
    assign cfg1.div_sel = monitor1_control_reg[smf_pkg::MON_DIV_LSB +: 2];
    assign cfg2.bypass = monitor2_control_reg[smf_pkg::MON_BYPASS_BIT];
    assign cfg2.div_sel = monitor2_control_reg[smf_pkg::MON_DIV_LSB +: 2];

    // ------------------------------------------------------------
    // Slow oscillator edge, gated by its stop bit
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            // Starts high: a clock already high at release is no false edge
            osc_prev_reg <= 1'b1;
        end else begin
            osc_prev_reg <= slow_osc_clock;
        end
    end

    // Stopped oscillator gives no ticks: filtered levels freeze
    assign slow_edge = slow_osc_clock && !osc_prev_reg &&
        !clock_mode_reg_one[smf_pkg::OSC_STOP_BIT];

    smf_filter u_filt1 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .slow_edge(slow_edge),
        .cfg(cfg1),
        .cmp_level(cmp1_below),
        .level_out(below1)
    );

    smf_filter u_filt2 (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .slow_edge(slow_edge),
        .cfg(cfg2),
        .cmp_level(cmp2_below),
        .level_out(below2)
    );

    // ------------------------------------------------------------
    // Monitor 1 reset
    // ------------------------------------------------------------
    assign mon1_armed = det1_circuit_enable &&
        monitor1_control_reg[smf_pkg::MON_ENABLE_BIT] &&
        monitor1_control_reg[smf_pkg::MON_MODE_BIT];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            int_reset_n_reg <= 1'b1;
        end else begin
            int_reset_n_reg <= !(mon1_armed && below1);
        end
    end

    // ------------------------------------------------------------
    // Monitor 2 crossing detection
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (soft_or_sys) begin
            below2_prev_reg <= 1'b0;
        end else begin
            below2_prev_reg <= below2;
        end
    end

    assign mon2_armed = det2_circuit_enable &&
        monitor2_control_reg[smf_pkg::MON_ENABLE_BIT];
    assign mon2_cross_up = below2_prev_reg && !below2;
    assign mon2_cross_down = !below2_prev_reg && below2;
    assign mon2_event = mon2_armed && (monitor2_control_reg[smf_pkg::MON_COND_BIT] ?
        mon2_cross_down : mon2_cross_up);

    always_ff @(posedge core_clk) begin
        if (soft_or_sys) begin
            mon2_irq_reg <= 1'b0;
        end else begin
            mon2_irq_reg <= mon2_event &&
                !monitor2_control_reg[smf_pkg::MON_MODE_BIT];
        end
    end

    // Reset request is stretched so the reset controller cannot miss it
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rst_cnt_reg <= 8'h00;
            mon2_reset_req_reg <= 1'b0;
        end else if (mon2_event && monitor2_control_reg[smf_pkg::MON_MODE_BIT]) begin
            rst_cnt_reg <= 8'(smf_pkg::MON2_RST_CYCLES - 1);
            mon2_reset_req_reg <= 1'b1;
        end else if (rst_cnt_reg != 8'h00) begin
            rst_cnt_reg <= rst_cnt_reg - 8'h01;
        end else begin
            mon2_reset_req_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sticky flags, kept through soft resets
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            chg_flag_reg <= 1'b0;
            wdt_flag_reg <= 1'b0;
        end else begin
            if (mon2_event) begin
                chg_flag_reg <= 1'b1;
            end else if (wr_mon2 && !reg_wdata[smf_pkg::MON_BIT2]) begin
                chg_flag_reg <= 1'b0;
            end
            if (wdt_event) begin
                wdt_flag_reg <= 1'b1;
            end else if (wr_mon2 && !reg_wdata[smf_pkg::MON2_WDT_FLAG_BIT]) begin
                wdt_flag_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status and read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            detect_status_reg <= 8'h08;
        end else begin
            detect_status_reg <= 8'h00;
            detect_status_reg[smf_pkg::LEVEL2_STAT_BIT] <=
                det2_circuit_enable ? !cmp2_below : 1'b1;
        end
    end

    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            smf_pkg::ADDR_DETECT_ENABLE: rdata_next = detect_enable_reg;
            smf_pkg::ADDR_DETECT_STATUS: rdata_next = detect_status_reg;
            smf_pkg::ADDR_MON1_CONTROL: rdata_next = monitor1_control_reg;
            smf_pkg::ADDR_MON2_CONTROL: begin
                rdata_next = monitor2_control_reg;
                rdata_next[smf_pkg::MON_BIT2] = chg_flag_reg;
                rdata_next[smf_pkg::MON2_WDT_FLAG_BIT] = wdt_flag_reg;
            end
            smf_pkg::ADDR_CLOCK_MODE_ONE: rdata_next = clock_mode_reg_one;
            default: rdata_next = 8'h00;
        endcase
    end

    // Data valid only in the cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= reg_rd ? rdata_next : 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;
    assign int_reset_n = int_reset_n_reg;
    assign mon2_irq = mon2_irq_reg;
    assign mon2_reset_req = mon2_reset_req_reg;
    assign slow_osc_stop = clock_mode_reg_one[smf_pkg::OSC_STOP_BIT];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    a_flag_set_wins: assert property (
        (mon2_event && wr_mon2 && !reg_wdata[smf_pkg::MON_BIT2]) |=> chg_flag_reg)
        else $error("change flag lost when event met clear");
    a_flag_one_keeps: assert property (
        (!chg_flag_reg && !mon2_event && wr_mon2) |=> !chg_flag_reg)
        else $error("change flag set by a software write");
    a_status_tracks_cmp: assert property (
        (det2_circuit_enable && !soft_rst) |=>
        detect_status_reg[smf_pkg::LEVEL2_STAT_BIT] == !$past(cmp2_below))
        else $error("level-2 status does not follow comparator");
    a_bypass_direct: assert property (
        (mon1_armed && cfg1.bypass && cmp1_below) |=> !int_reset_n)
        else $error("bypassed monitor 1 did not reset at once");
    a_mon1_idle_high: assert property (
        !mon1_armed |=> int_reset_n)
        else $error("internal reset while monitor 1 unarmed");
    a_irq_mode_zero: assert property (
        mon2_irq |-> !$past(monitor2_control_reg[smf_pkg::MON_MODE_BIT]))
        else $error("interrupt raised in reset mode");
    a_rst_mode_one: assert property (
        $rose(mon2_reset_req) |-> $past(monitor2_control_reg[smf_pkg::MON_MODE_BIT])
        ##1 mon2_reset_req [*3])
        else $error("monitor-2 reset in wrong mode or too short");
    a_cross_direction: assert property (
        mon2_irq |-> ($past(monitor2_control_reg[smf_pkg::MON_COND_BIT]) ?
        $past(below2) : !$past(below2)))
        else $error("monitor-2 event in wrong direction");
    a_flags_survive: assert property (
        (soft_rst && !mon2_event && !wdt_event && !wr_mon2) |=>
        chg_flag_reg == $past(chg_flag_reg) && wdt_flag_reg == $past(wdt_flag_reg))
        else $error("detection flags lost on soft reset");

    c_mon1_reset: cover property (mon1_armed && !cfg1.bypass ##1 !int_reset_n);
    c_mon2_irq: cover property (mon2_irq);
    c_mon2_rst: cover property ($rose(mon2_reset_req));
    c_flag_clear: cover property (chg_flag_reg ##1 !chg_flag_reg);
endmodule : smf_monitor_ctrl

`default_nettype wire

// ==== test/smf_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Comparators and slow oscillator
// ------------------------------------------------------------
module smf_analog_model #(
    parameter int SLOW_HALF = 4
) (
    input wire logic core_clk,
    input wire logic osc_stop,
    input wire logic supply1_low,
    input wire logic supply2_low,
    output logic slow_osc_clock,
    output logic cmp1_below,
    output logic cmp2_below
);
    int half_cnt = 0;
    logic slow_q = 1'b0;

    // Stopped oscillator gives no edges at all
    always @(posedge core_clk) begin
        if (osc_stop) begin
            half_cnt <= 0;
        end else if (half_cnt == SLOW_HALF - 1) begin
            half_cnt <= 0;
            slow_q <= ~slow_q;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end

    assign slow_osc_clock = slow_q;
    assign cmp1_below = supply1_low;
    assign cmp2_below = supply2_low;
endmodule : smf_analog_model

`default_nettype wire

// ==== test/supply_monitor_filter_ctrl_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module supply_monitor_filter_ctrl_test;
    localparam int SLOW_HALF = 4;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic soft_rst = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic wdt_event = 1'b0;
    logic supply1_low = 1'b0;
    logic supply2_low = 1'b0;
    logic [7:0] reg_rdata;
    logic slow_osc_clock, cmp1_below, cmp2_below;
    logic int_reset_n, mon2_irq, mon2_reset_req, slow_osc_stop;
    int errors = 0;
    int tests_run = 0;
    int slow_edges = 0;
    logic slow_d = 1'b0;
    logic rd_q = 1'b0;
    logic [7:0] exp_q[$];
    logic [31:0] rnd = 32'h42cc241f;

    smf_monitor_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .slow_osc_clock(slow_osc_clock), .cmp1_below(cmp1_below),
        .cmp2_below(cmp2_below), .wdt_event(wdt_event), .int_reset_n(int_reset_n),
        .mon2_irq(mon2_irq), .mon2_reset_req(mon2_reset_req), .slow_osc_stop(slow_osc_stop));

    smf_analog_model #(.SLOW_HALF(SLOW_HALF)) i_analog (.core_clk(core_clk),
        .osc_stop(slow_osc_stop), .supply1_low(supply1_low), .supply2_low(supply2_low),
        .slow_osc_clock(slow_osc_clock), .cmp1_below(cmp1_below), .cmp2_below(cmp2_below));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic test_done();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask : chk1

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(exp);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask : rd

    function automatic logic cur(input int w);
        case (w)
            0: return int_reset_n;
            1: return mon2_irq;
            default: return mon2_reset_req;
        endcase
    endfunction

    task automatic wait_for(input int w, input logic lvl, input int lim);
        int k;
        k = 0;
        while (cur(w) !== lvl && k < lim) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        chk1(cur(w), lvl);
    endtask : wait_for

    // ------------------------------------------------------------
    // Read data checker and slow edge counter
    // ------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rd_q) chk8(reg_rdata, exp_q.pop_front());
        rd_q <= reg_rd;
        slow_d <= slow_osc_clock;
        if (slow_osc_clock && !slow_d) slow_edges <= slow_edges + 1;
    end

    initial begin
        #400000;
        errors++;
        test_done();
    end

    initial begin
        int n;
        int e0;
        int nd;
        logic [7:0] d;
        logic [2:0] ra;
        logic [7:0] rm;
        tick(4);
        sys_rst <= 1'b0;
        for (int a = 0; a < 6; a++) rd(a[2:0], (a == 1) ? 8'h08 : 8'h00);
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            d = rnd[7:0] & 8'hfe;
            ra = 3'(2 * (i % 3));
            rm = (i % 3 == 0) ? 8'hc0 : ((i % 3 == 1) ? 8'hf6 : 8'h10);
            wr(ra, d);
            rd(ra, d & rm);
        end
        @(posedge core_clk) sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        rd(3'h2, 8'h00);
        // Level-2 status follows comparator once circuit 2 is on
        wr(3'h0, 8'h80);
        @(posedge core_clk) supply2_low <= 1'b1;
        tick(3);
        rd(3'h1, 8'h00);
        @(posedge core_clk) supply2_low <= 1'b0;
        tick(3);
        rd(3'h1, 8'h08);
        // Monitor 2, bypass, interrupt on both crossing directions
        @(posedge core_clk) supply2_low <= 1'b1;
        wr(3'h3, 8'h00);
        wr(3'h3, 8'h02);
        wr(3'h3, 8'h03);
        @(posedge core_clk) supply2_low <= 1'b0;
        wait_for(1, 1'b1, 4);
        chk1(mon2_reset_req, 1'b0);
        @(posedge core_clk);
        #1 chk1(mon2_irq, 1'b0);
        rd(3'h3, 8'h07);
        wr(3'h3, 8'h83);
        rd(3'h3, 8'h83);
        @(posedge core_clk) supply2_low <= 1'b1;
        wait_for(1, 1'b1, 4);
        wr(3'h3, 8'h87);
        rd(3'h3, 8'h87);
        @(posedge core_clk) wdt_event <= 1'b1;
        @(posedge core_clk) wdt_event <= 1'b0;
        rd(3'h3, 8'h8f);
        @(posedge core_clk) soft_rst <= 1'b1;
        @(posedge core_clk) soft_rst <= 1'b0;
        rd(3'h3, 8'h0c);
        wr(3'h3, 8'h00);
        rd(3'h3, 8'h00);
        // Soft reset cleared the circuit enables
        wr(3'h0, 8'h80);
        // Monitor 2 reset mode on a falling supply
        @(posedge core_clk) supply2_low <= 1'b0;
        wr(3'h3, 8'h82);
        wr(3'h3, 8'hc2);
        wr(3'h3, 8'hc3);
        @(posedge core_clk) supply2_low <= 1'b1;
        wait_for(2, 1'b1, 4);
        n = 0;
        while (mon2_reset_req === 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk8(n[7:0], smf_pkg::MON2_RST_CYCLES[7:0]);
        // Monitor 1 bypass with the oscillator stopped, wake-from-stop case
        wr(3'h4, 8'h10);
        #1 chk1(slow_osc_stop, 1'b1);
        wr(3'h0, 8'h40);
        tick(4);
        wr(3'h2, 8'h80);
        wr(3'h2, 8'h82);
        wr(3'h2, 8'hc2);
        wr(3'h2, 8'hc3);
        e0 = slow_edges;
        @(posedge core_clk) supply1_low <= 1'b1;
        wait_for(0, 1'b0, 3);
        chk1(slow_edges == e0, 1'b1);
        @(posedge core_clk) supply1_low <= 1'b0;
        wait_for(0, 1'b1, 3);
        // Filtered monitor 1 for every divider setting
        for (int dv = 0; dv < 4; dv++) begin
            nd = 1 << dv;
            wr(3'h2, 8'h00);
            wr(3'h4, 8'h00);
            wr(3'h2, {2'b01, dv[1:0], 4'h0});
            tick(8 * nd * SLOW_HALF);
            wr(3'h2, {2'b01, dv[1:0], 4'h1});
            if (dv == 0) begin
                @(posedge core_clk) supply1_low <= 1'b1;
                tick(4);
                supply1_low <= 1'b0;
                for (int k = 0; k < 48; k++) begin
                    @(posedge core_clk);
                    #1 chk1(int_reset_n, 1'b1);
                end
            end
            @(posedge core_clk) supply1_low <= 1'b1;
            e0 = slow_edges;
            wait_for(0, 1'b0, 4 * nd * SLOW_HALF + 20);
            n = slow_edges - e0;
            chk1(n >= nd && n <= 2 * nd + 1, 1'b1);
            @(posedge core_clk) supply1_low <= 1'b0;
            wait_for(0, 1'b1, 4 * nd * SLOW_HALF + 20);
        end
        // Monitor 2 filtered, divide by 2, interrupt on a rising supply
        wr(3'h3, 8'h00);
        wr(3'h0, 8'hc0);
        wr(3'h3, 8'h10);
        tick(8 * 2 * SLOW_HALF);
        wr(3'h3, 8'h11);
        @(posedge core_clk) supply2_low <= 1'b0;
        wait_for(1, 1'b1, 4 * 2 * SLOW_HALF + 20);
        chk1(mon2_reset_req, 1'b0);
        rd(3'h3, 8'h15);
        tick(4);
        test_done();
    end
endmodule : supply_monitor_filter_ctrl_test

`default_nettype wire
